// >>> dmap_top.sv
// Process-data front end: command decode, state encode, mapping checks
// Behaviour
// - Command bits 0..3 drive the drive-state machine.
// - Rising bit 7 clears pending faults and warnings; the code clears faults only, state-word bit 7 just follows warning_in.
// - Quick stop while running decelerates; no run until motor stopped.
// - Target speed is signed rpm, sign gives direction.
// - Speed beyond maximum saturates to maximum, never rejected.
// - State word bits 0..6 report the drive state.
// - State word bit 7 is the warning flag.
// - State word bit 9 shows remote control enabled.
// - Actual speed returned as signed rpm.
// - Each mapping PDO holds at most two objects, four bytes total.
// - Each assignment accepts at most five PDOs.
// - Receive PDO never mixes vendor and drive profile objects.
// - Receive assignment refuses a PDO mixing vendor and drive objects.
// - Parameter objects in receive PDO only if changeable while running.
// - Half of a 32-bit object alone is never mapped.
// - Process data refresh every 4 ms, up to 6 ms with more PDOs.
// - Image words in assignment order, 32-bit object low half first.
// - Fixed profile words come first, free PDOs follow.
// - Command bit patterns decode to five of the seven drive commands.
// - Each drive state has a fixed state-word bit pattern.
`default_nettype none
module dmap_top
    import dmap_pkg::*;
#(
    parameter int BASE_CYC = CYCLE_BASE_CYC,
    parameter int MAX_CYC  = CYCLE_MAX_CYC
)(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Inverter core status
    input  wire logic [15:0] max_speed,
    input  wire logic [15:0] core_speed,
    input  wire logic        motor_stopped,
    input  wire logic        fault_in,
    input  wire logic        warning_in,
    input  wire logic        remote_in,
    input  wire logic        live_ok,
    // Inverter core control
    output logic      [15:0] speed_ref,
    output logic             run_enable_out,
    output logic             decel_stop,
    output logic             fault_clear,
    output logic             cycle_tick
);
    localparam int STEP_CYC = (MAX_CYC - BASE_CYC) / (2 * NUM_SLOTS);
    // Count of set bits in an assignment mask
    function automatic logic [3:0] popcount(input logic [7:0] m);
        logic [3:0] n;
        n = '0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, m[i]};
        end
        return n;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [15:0]      rx_cmd_q, rx_cmd_d;
    logic [15:0]      rx_speed_q, rx_speed_d;
    logic [22:0]      map_entry_q, map_entry_d;
    logic [15:0]      assign_q, assign_d;
    logic [ERR_W-1:0] err_q, err_d;
    logic [1:0]       cnt_q   [0:2*NUM_SLOTS-1], cnt_d   [0:2*NUM_SLOTS-1];
    logic [2:0]       bytes_q [0:2*NUM_SLOTS-1], bytes_d [0:2*NUM_SLOTS-1];
    logic             vend_q  [0:2*NUM_SLOTS-1], vend_d  [0:2*NUM_SLOTS-1];
    logic             drv_q   [0:2*NUM_SLOTS-1], drv_d   [0:2*NUM_SLOTS-1];
    logic [ERR_W-1:0] ent_err, assn_err;
    logic [3:0]       ent_idx;
    logic             wr_entry, wr_assign;
    assign wr_entry  = reg_wr && (reg_addr == OFF_MAP_ENTRY);
    assign wr_assign = reg_wr && (reg_addr == OFF_SM_ASSIGN);
    assign ent_idx   = (reg_wdata[ME_DIR] ? 4'(NUM_SLOTS) : 4'h0) + {1'b0, reg_wdata[ME_SLOT +: 3]};
    dmap_map_check u_check (
        .obj        (reg_wdata[15:0]),
        .size32     (reg_wdata[ME_SIZE32]),
        .half       (reg_wdata[ME_HALF]),
        .dir_tx     (reg_wdata[ME_DIR]),
        .slot       (reg_wdata[ME_SLOT +: 3]),
        .live_ok    (live_ok),
        .cur_cnt    (cnt_q[ent_idx]),
        .cur_bytes  (bytes_q[ent_idx]),
        .cur_vendor (vend_q[ent_idx]),
        .cur_drive  (drv_q[ent_idx]),
        .err        (ent_err)
    );
    // Assignment check: slot count and mixed receive PDOs
    always_comb begin
        assn_err = '0;
        assn_err[ERR_ASSN] = (popcount(reg_wdata[7:0]) > MAX_PDOS) || (reg_wdata[7:5] != 3'h0)
                             || (popcount(reg_wdata[15:8]) > MAX_PDOS) || (reg_wdata[15:13] != 3'h0);
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (reg_wdata[i] && vend_q[i] && drv_q[i]) begin
                assn_err[ERR_AMIX] = 1'b1;
            end
        end
    end
    // Register writes; refused entries and assignments leave state as it was
    always_comb begin
        rx_cmd_d    = rx_cmd_q;
        rx_speed_d  = rx_speed_q;
        map_entry_d = map_entry_q;
        assign_d    = assign_q;
        err_d       = err_q;
        cnt_d       = cnt_q;
        bytes_d     = bytes_q;
        vend_d      = vend_q;
        drv_d       = drv_q;
        if (reg_wr && reg_addr == OFF_RX_CMD) begin
            rx_cmd_d = reg_wdata[15:0];
        end
        if (reg_wr && reg_addr == OFF_RX_SPEED) begin
            rx_speed_d = reg_wdata[15:0];
        end
        // Clear first so a refusal in the same cycle still shows
        if (reg_wr && reg_addr == OFF_MAP_STATUS) begin
            err_d = err_q & ~reg_wdata[ERR_W-1:0];
        end
        if (wr_entry && reg_wdata[ME_CLEAR] && (ent_idx < 4'(2 * NUM_SLOTS))) begin
            cnt_d[ent_idx]   = '0;
            bytes_d[ent_idx] = '0;
            vend_d[ent_idx]  = 1'b0;
            drv_d[ent_idx]   = 1'b0;
        end else if (wr_entry && (ent_err != '0)) begin
            err_d = err_d | ent_err;
        end else if (wr_entry) begin
            map_entry_d      = reg_wdata[22:0];
            cnt_d[ent_idx]   = cnt_q[ent_idx] + 2'h1;
            bytes_d[ent_idx] = bytes_q[ent_idx] + (reg_wdata[ME_SIZE32] ? 3'h4 : 3'h2);
            vend_d[ent_idx]  = vend_q[ent_idx] || (reg_wdata[15:0] inside {[OBJ_VENDOR_LO:OBJ_VENDOR_HI]});
            drv_d[ent_idx]   = drv_q[ent_idx] || (reg_wdata[15:0] inside {[OBJ_DRIVE_LO:OBJ_DRIVE_HI]});
        end
        if (wr_assign && (assn_err != '0)) begin
            err_d = err_d | assn_err;
        end else if (wr_assign) begin
            assign_d = reg_wdata[15:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_cmd_q    <= '0;
            rx_speed_q  <= '0;
            map_entry_q <= '0;
            assign_q    <= '0;
            err_q       <= '0;
            for (int i = 0; i < 2 * NUM_SLOTS; i++) begin
                cnt_q[i]   <= '0;
                bytes_q[i] <= '0;
                vend_q[i]  <= 1'b0;
                drv_q[i]   <= 1'b0;
            end
        end else begin
            rx_cmd_q    <= rx_cmd_d;
            rx_speed_q  <= rx_speed_d;
            map_entry_q <= map_entry_d;
            assign_q    <= assign_d;
            err_q       <= err_d;
            cnt_q       <= cnt_d;
            bytes_q     <= bytes_d;
            vend_q      <= vend_d;
            drv_q       <= drv_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Image size: fixed words first, then assigned free PDOs in slot order
    logic [7:0] rx_words, tx_words;
    logic [3:0] npdo;
    always_comb begin
        rx_words = FIXED_WORDS;
        tx_words = FIXED_WORDS;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (assign_q[i]) begin
                rx_words = rx_words + {6'h0, bytes_q[i][2:1]};
            end
            if (assign_q[SA_TX + i]) begin
                tx_words = tx_words + {6'h0, bytes_q[NUM_SLOTS + i][2:1]};
            end
        end
        npdo = popcount(assign_q[7:0]) + popcount(assign_q[15:8]);
    end
    ////////////////////////////////////////////////////////////////////////
    // Refresh timer: base period stretched per assigned PDO
    logic [31:0] period;
    logic [31:0] tmr_q, tmr_d;
    logic        tick_d;
    assign period = 32'(BASE_CYC) + 32'(STEP_CYC) * {28'h0, npdo};
    always_comb begin
        tick_d = (tmr_q >= period - 32'h1);
        tmr_d  = tick_d ? 32'h0 : tmr_q + 32'h1;
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tmr_q      <= '0;
            cycle_tick <= 1'b0;
        end else begin
            tmr_q      <= tmr_d;
            cycle_tick <= tick_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Drive state machine; commands act once per refresh, fault and power-up steps every clock
    dmap_cmd_t   cmd;
    dmap_state_t st_q, st_d;
    logic        clr_prev_q, clr_prev_d;
    logic        halt_q, halt_d;
    logic        fclr_d;
    dmap_cmd_decode u_dec (
        .cmd_word (rx_cmd_q),
        .cmd      (cmd)
    );
    always_comb begin
        st_d       = st_q;
        clr_prev_d = clr_prev_q;
        halt_d     = halt_q && !motor_stopped;
        fclr_d     = 1'b0;
        if (tick_d) begin
            clr_prev_d = rx_cmd_q[CMD_FAULT_CLEAR];
            fclr_d     = rx_cmd_q[CMD_FAULT_CLEAR] && !clr_prev_q;
        end
        if (fault_in && st_q != DS_FAULT && st_q != DS_FLT_REACT) begin
            st_d = DS_FLT_REACT;
        end else begin
            case (st_q)
                DS_NOT_READY: st_d = DS_SW_ON_DIS;
                DS_FLT_REACT: st_d = DS_FAULT;
                DS_FAULT: begin
                    if (fclr_d) begin
                        st_d = DS_SW_ON_DIS;
                    end
                end
                DS_SW_ON_DIS: begin
                    if (tick_d && cmd == DC_SHUTDOWN) begin
                        st_d = DS_READY;
                    end
                end
                DS_READY: begin
                    if (tick_d && (cmd == DC_DIS_VOLT || cmd == DC_QSTOP)) begin
                        st_d = DS_SW_ON_DIS;
                    end else if (tick_d && (cmd == DC_SWITCH_ON || cmd == DC_EN_OP)) begin
                        st_d = DS_SWITCHED;
                    end
                end
                DS_SWITCHED: begin
                    if (tick_d && (cmd == DC_DIS_VOLT || cmd == DC_QSTOP)) begin
                        st_d = DS_SW_ON_DIS;
                    end else if (tick_d && cmd == DC_SHUTDOWN) begin
                        st_d = DS_READY;
                    end else if (tick_d && cmd == DC_EN_OP && !halt_q) begin
                        st_d = DS_OP_EN;
                    end
                end
                DS_OP_EN: begin
                    if (tick_d && cmd == DC_QSTOP) begin
                        st_d   = DS_SW_ON_DIS;
                        halt_d = 1'b1;
                    end else if (tick_d && cmd == DC_DIS_VOLT) begin
                        st_d = DS_SW_ON_DIS;
                    end else if (tick_d && cmd == DC_SHUTDOWN) begin
                        st_d = DS_READY;
                    end else if (tick_d && cmd == DC_SWITCH_ON) begin
                        st_d = DS_SWITCHED;
                    end
                end
                default: st_d = DS_NOT_READY;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q        <= DS_NOT_READY;
            clr_prev_q  <= 1'b0;
            halt_q      <= 1'b0;
            fault_clear <= 1'b0;
        end else begin
            st_q        <= st_d;
            clr_prev_q  <= clr_prev_d;
            halt_q      <= halt_d;
            fault_clear <= fclr_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Speed reference every clock; transmitted words refreshed once per refresh
    logic signed [15:0] tgt;
    logic signed [15:0] vmax;
    logic signed [15:0] sat;
    logic [15:0]        st_word_q, st_word_d;
    logic [15:0]        act_q, act_d;
    logic [15:0]        sref_d;
    logic [6:0]         pat;
    assign tgt  = signed'(rx_speed_q);
    assign vmax = signed'({1'b0, max_speed[14:0]});
    always_comb begin
        if (tgt > vmax) begin
            sat = vmax;
        end else if (tgt < -vmax) begin
            sat = -vmax;
        end else begin
            sat = tgt;
        end
        case (st_q)
            DS_SW_ON_DIS: pat = 7'b1100000;
            DS_READY:     pat = 7'b0100001;
            DS_SWITCHED:  pat = 7'b0110011;
            DS_OP_EN:     pat = 7'b0110111;
            DS_FLT_REACT: pat = 7'b0101111;
            DS_FAULT:     pat = 7'b0101000;
            default:      pat = 7'b0000000;
        endcase
        st_word_d = st_word_q;
        act_d     = act_q;
        if (tick_d) begin
            st_word_d = {6'h00, remote_in, 1'b0, warning_in, pat};
            act_d     = core_speed;
        end
        sref_d = (st_q == DS_OP_EN) ? 16'(sat) : 16'h0000;
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_word_q      <= '0;
            act_q          <= '0;
            speed_ref      <= '0;
            run_enable_out <= 1'b0;
            decel_stop     <= 1'b0;
        end else begin
            st_word_q      <= st_word_d;
            act_q          <= act_d;
            speed_ref      <= sref_d;
            run_enable_out <= (st_q == DS_OP_EN);
            decel_stop     <= halt_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe, zero otherwise
    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFF_RX_CMD:     rdata_d = {16'h0, rx_cmd_q};
                OFF_RX_SPEED:   rdata_d = {16'h0, rx_speed_q};
                OFF_TX_STATE:   rdata_d = {16'h0, st_word_q};
                OFF_TX_SPEED:   rdata_d = {16'h0, act_q};
                OFF_MAP_ENTRY:  rdata_d = {9'h0, map_entry_q};
                OFF_SM_ASSIGN:  rdata_d = {16'h0, assign_q};
                OFF_MAP_STATUS: rdata_d = {tx_words, rx_words, 4'h0, npdo, 1'b0, err_q};
                OFF_CYCLE_LEN:  rdata_d = period;
                default:        rdata_d = '0;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rdata_d;
        end
    end
endmodule
`default_nettype wire

// >>> dmap_pkg.sv
// Shared constants for the drive process-data mapper
`default_nettype none
package dmap_pkg;
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] OFF_RX_CMD     = 8'h00;
    localparam logic [7:0] OFF_RX_SPEED   = 8'h04;
    localparam logic [7:0] OFF_TX_STATE   = 8'h08;
    localparam logic [7:0] OFF_TX_SPEED   = 8'h0C;
    localparam logic [7:0] OFF_MAP_ENTRY  = 8'h10;
    localparam logic [7:0] OFF_SM_ASSIGN  = 8'h14;
    localparam logic [7:0] OFF_MAP_STATUS = 8'h18;
    localparam logic [7:0] OFF_CYCLE_LEN  = 8'h1C;
    // Command word bits
    localparam int CMD_SWITCH_ON   = 0;
    localparam int CMD_POWER_EN    = 1;
    localparam int CMD_FAST_HALT   = 2;
    localparam int CMD_RUN_EN      = 3;
    localparam int CMD_FAULT_CLEAR = 7;
    // State word bits
    localparam int ST_WARNING = 7;
    localparam int ST_REMOTE  = 9;
    // Map entry fields
    localparam int ME_SIZE32 = 16;
    localparam int ME_HALF   = 17;
    localparam int ME_SLOT   = 18;
    localparam int ME_DIR    = 21;
    localparam int ME_CLEAR  = 22;
    // Assignment fields
    localparam int SA_TX = 8;
    // Mapping limits
    localparam logic [1:0] MAX_OBJS      = 2'h2;
    localparam logic [2:0] MAX_BYTES     = 3'h4;
    localparam logic [3:0] MAX_PDOS      = 4'h5;
    localparam int         NUM_SLOTS     = 5;
    localparam logic [7:0] FIXED_WORDS   = 8'h02;
    // Object index ranges
    localparam logic [15:0] OBJ_PARAM_LO  = 16'h3000;
    localparam logic [15:0] OBJ_PARAM_HI  = 16'h4999;
    localparam logic [15:0] OBJ_VENDOR_LO = 16'h5000;
    localparam logic [15:0] OBJ_VENDOR_HI = 16'h5999;
    localparam logic [15:0] OBJ_DRIVE_LO  = 16'h6000;
    localparam logic [15:0] OBJ_DRIVE_HI  = 16'h6999;
    // Error flag positions
    localparam int ERR_COUNT = 0;
    localparam int ERR_SIZE  = 1;
    localparam int ERR_MIX   = 2;
    localparam int ERR_LIVE  = 3;
    localparam int ERR_HALF  = 4;
    localparam int ERR_ASSN  = 5;
    localparam int ERR_AMIX  = 6;
    localparam int ERR_W     = 7;
    // Refresh timing
    localparam int CLK_MHZ        = 10;
    localparam int CYCLE_BASE_US  = 4000;
    localparam int CYCLE_MAX_US   = 6000;
    localparam int CYCLE_BASE_CYC = CYCLE_BASE_US * CLK_MHZ;
    localparam int CYCLE_MAX_CYC  = CYCLE_MAX_US * CLK_MHZ;
    // Drive commands
    typedef enum logic [2:0] {
        DC_NONE      = 3'h0,
        DC_SHUTDOWN  = 3'h1,
        DC_SWITCH_ON = 3'h2,
        DC_DIS_VOLT  = 3'h3,
        DC_QSTOP     = 3'h4,
        DC_DIS_OP    = 3'h5,
        DC_EN_OP     = 3'h6
    } dmap_cmd_t;
    // Drive states
    typedef enum logic [2:0] {
        DS_NOT_READY = 3'h0,
        DS_SW_ON_DIS = 3'h1,
        DS_READY     = 3'h2,
        DS_SWITCHED  = 3'h3,
        DS_OP_EN     = 3'h4,
        DS_FLT_REACT = 3'h5,
        DS_FAULT     = 3'h6
    } dmap_state_t;
endpackage
`default_nettype wire

// >>> dmap_cmd_decode.sv
// Command word decoder for the drive state machine
`default_nettype none
module dmap_cmd_decode
    import dmap_pkg::*;
(
    // Command word in
    input  wire logic [15:0] cmd_word,
    // Decoded command out
    output var dmap_cmd_t    cmd
);
    // Priority: voltage off beats quick stop beats the rest
    always_comb begin
        if (!cmd_word[CMD_POWER_EN]) begin
            cmd = DC_DIS_VOLT;
        end else if (!cmd_word[CMD_FAST_HALT]) begin
            cmd = DC_QSTOP;
        end else if (!cmd_word[CMD_SWITCH_ON]) begin
            cmd = DC_SHUTDOWN;
        end else if (cmd_word[CMD_RUN_EN]) begin
            cmd = DC_EN_OP;
        end else begin
            cmd = DC_SWITCH_ON;
        end
    end
endmodule
`default_nettype wire

// >>> dmap_map_check.sv
// Validation of one PDO mapping entry against the slot it joins
`default_nettype none
module dmap_map_check
    import dmap_pkg::*;
(
    // Entry
    input  wire logic [15:0]      obj,
    input  wire logic             size32,
    input  wire logic             half,
    input  wire logic             dir_tx,
    input  wire logic [2:0]       slot,
    input  wire logic             live_ok,
    // Current slot contents
    input  wire logic [1:0]       cur_cnt,
    input  wire logic [2:0]       cur_bytes,
    input  wire logic             cur_vendor,
    input  wire logic             cur_drive,
    // Verdict
    output logic [ERR_W-1:0]      err
);
    logic       is_vendor;
    logic       is_drive;
    logic       is_param;
    logic [3:0] new_bytes;

    assign is_vendor = (obj >= OBJ_VENDOR_LO) && (obj <= OBJ_VENDOR_HI);
    assign is_drive  = (obj >= OBJ_DRIVE_LO) && (obj <= OBJ_DRIVE_HI);
    assign is_param  = (obj >= OBJ_PARAM_LO) && (obj <= OBJ_PARAM_HI);
    assign new_bytes = {1'b0, cur_bytes} + (size32 ? 4'h4 : 4'h2);

    // Each failing check raises its own flag
    always_comb begin
        err = '0;
        err[ERR_COUNT] = (slot >= 3'(NUM_SLOTS)) || (cur_cnt >= MAX_OBJS);
        err[ERR_SIZE]  = new_bytes > {1'b0, MAX_BYTES};
        err[ERR_MIX]   = !dir_tx && ((is_vendor && cur_drive) || (is_drive && cur_vendor));
        err[ERR_LIVE]  = !dir_tx && is_param && !live_ok;
        err[ERR_HALF]  = half;
    end
endmodule
`default_nettype wire

// >>> dmap_top_props.sv
// Port-level checks for the process-data mapper
`default_nettype none
module dmap_top_props #(
    parameter int BASE_CYC = 40,
    parameter int MAX_CYC  = 60
)(
    // Clock, reset and register read side
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Inverter core side
    input wire logic [15:0] max_speed,
    input wire logic [15:0] speed_ref,
    input wire logic        run_enable_out,
    input wire logic        decel_stop,
    input wire logic        motor_stopped,
    input wire logic        fault_clear,
    input wire logic        cycle_tick
);
    logic [15:0] gap_q, gap_d;
    logic        seen_q, seen_d;
    ////////////////////////////////////////
    // Cycles since last refresh; the first tick has no period to judge
    always_comb begin
        gap_d  = cycle_tick ? 16'h0 : gap_q + 16'h1;
        seen_d = seen_q | cycle_tick;
    end
    always_ff @(posedge sys_clk) begin
        gap_q  <= srst ? 16'h0 : gap_d;
        seen_q <= srst ? 1'b0 : seen_d;
    end
    ////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_run_end;
        $fell(run_enable_out);
    endsequence
    sequence s_ref_idle;
        (speed_ref == 16'h0000) [*2];
    endsequence
    a_read_slot: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_tick_single: assert property (cycle_tick |=> !cycle_tick)
        else $error("refresh pulse too long");
    a_tick_period: assert property (cycle_tick && seen_q |->
        gap_q >= 16'(BASE_CYC - 1) && gap_q <= 16'(MAX_CYC - 1)) else $error("refresh period out of span");
    a_clear_single: assert property (fault_clear |=> !fault_clear)
        else $error("fault clear pulse too long");
    a_decel_holds: assert property (decel_stop && !motor_stopped |=> decel_stop)
        else $error("stop released before standstill");
    a_decel_blocks: assert property (decel_stop |=> !run_enable_out)
        else $error("running during decelerating stop");
    a_run_entry: assert property ($rose(run_enable_out) |-> !$past(decel_stop))
        else $error("run entered while stopping");
    a_speed_bound: assert property ($signed(speed_ref) <= $signed({1'b0, max_speed[14:0]}) &&
        $signed(speed_ref) >= -$signed({1'b0, max_speed[14:0]})) else $error("speed not saturated");
    a_stop_zero: assert property (s_run_end |-> ##1 s_ref_idle)
        else $error("speed reference kept after run");
endmodule
bind dmap_top dmap_top_props #(.BASE_CYC(BASE_CYC), .MAX_CYC(MAX_CYC)) i_props (.*);
`default_nettype wire

// >>> dmap_master.sv
// Register-port bus master model
`default_nettype none
module dmap_master (
    // Clock
    input  wire logic        sys_clk,
    // Register port
    output var  logic [7:0]  reg_addr,
    output var  logic [31:0] reg_wdata,
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    input  wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 42'h0;
    // Released data lines show the inverse so a stale value cannot pass
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// >>> test_drive_process_data_mapper.sv
// Self-checking bench for the process-data mapper
`default_nettype none
module test_drive_process_data_mapper
    import dmap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] cmd;
        logic [15:0] spd;
        logic [3:0]  ctl;    // Fault, warning, remote, motor stopped
        logic        decel;
        logic [15:0] state;
        logic [15:0] sref;
    } dmap_row_t;
    logic        sys_clk, srst, reg_wr, reg_rd, motor_stopped, fault_in, warning_in, remote_in, live_ok;
    logic        run_enable_out, decel_stop, fault_clear, cycle_tick;
    logic        clr_seen = 1'b0;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rdat;
    logic [15:0] max_speed, core_speed, speed_ref;
    int          err_total = 0;
    int          samples_checked = 0;
    // Commands, quick stop, refused run, fault clear
    dmap_row_t rows [15] = '{'{16'h0000, 16'h0000, 4'h0, 1'b0, 16'h0060, 16'h0000},
        '{16'h0006, 16'h0000, 4'h2, 1'b0, 16'h0221, 16'h0}, '{16'h0007, 16'h0000, 4'h2, 1'b0, 16'h0233, 16'h0},
        '{16'h000F, 16'h1000, 4'h2, 1'b0, 16'h0237, 16'h0BB8}, '{16'h000F, 16'hF000, 4'h6, 1'b0, 16'h02B7, 16'hF448},
        '{16'h0007, 16'h0100, 4'h2, 1'b0, 16'h0233, 16'h0}, '{16'h000F, 16'h0100, 4'h2, 1'b0, 16'h0237, 16'h0100},
        '{16'h0002, 16'h0100, 4'h2, 1'b1, 16'h0260, 16'h0}, '{16'h0006, 16'h0100, 4'h2, 1'b1, 16'h0221, 16'h0},
        '{16'h0007, 16'h0100, 4'h2, 1'b1, 16'h0233, 16'h0}, '{16'h000F, 16'h0100, 4'h2, 1'b1, 16'h0233, 16'h0},
        '{16'h000F, 16'h0100, 4'h3, 1'b0, 16'h0237, 16'h0100}, '{16'h000F, 16'h0100, 4'hB, 1'b0, 16'h0228, 16'h0},
        '{16'h0080, 16'h0100, 4'h3, 1'b0, 16'h0260, 16'h0}, '{16'h0000, 16'h0100, 4'h3, 1'b0, 16'h0260, 16'h0}};
    // Refused entries around one accepted vendor entry, and sticky error bits
    logic [31:0] ents [5] = '{32'h0000_5000, 32'h0004_5000, 32'h0004_6040, 32'h0008_3010, 32'h000B_4011};
    logic [6:0]  errs [5] = '{7'h02, 7'h02, 7'h06, 7'h0E, 7'h1E};
    ////////////////////////////////////////
    dmap_top #(.BASE_CYC(40), .MAX_CYC(60)) i_dut (.*);
    dmap_master i_mst (.*);
    ////////////////////////////////////////
    // Clock and fault-clear pulse watcher
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (fault_clear === 1'b1) clr_seen <= 1'b1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Bounded wait for one refresh pulse
    task automatic wait_tick();
        for (int n = 0; n < 100; n++) begin
            @(negedge sys_clk);
            if (cycle_tick === 1'b1) return;
        end
        err_total++;
        end_of_test();
    endtask
    ////////////////////////////////////////
    initial begin
        {srst, max_speed, core_speed} = {1'b1, 16'h0BB8, 16'h0};
        {motor_stopped, fault_in, warning_in, remote_in, live_ok} = 5'h01;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        i_mst.rd(OFF_TX_STATE, rdat);
        chk(rdat, 32'h0);
        for (int i = 0; i < 15; i++) begin
            @(posedge sys_clk);
            {fault_in, warning_in, remote_in, motor_stopped} <= rows[i].ctl;
            core_speed <= rows[i].spd;
            i_mst.wr(OFF_RX_SPEED, {16'h0, rows[i].spd});
            i_mst.wr(OFF_RX_CMD, {16'h0, rows[i].cmd});
            repeat (3) wait_tick();
            i_mst.rd(OFF_TX_STATE, rdat);
            chk(rdat, {16'h0, rows[i].state});
            i_mst.rd(OFF_TX_SPEED, rdat);
            chk(rdat, 32'(rows[i].spd));
            chk(32'(decel_stop), 32'(rows[i].decel));
            chk(32'(speed_ref), 32'(rows[i].sref));
        end
        chk(32'(clr_seen), 32'h1);
        // One 32-bit object in receive slot 0
        i_mst.wr(OFF_MAP_ENTRY, 32'h0001_4011);
        i_mst.wr(OFF_SM_ASSIGN, 32'h0000_0001);
        i_mst.rd(OFF_MAP_STATUS, rdat);
        chk(rdat, 32'h0204_0100);
        i_mst.rd(OFF_CYCLE_LEN, rdat);
        chk(rdat, 32'd42);
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            live_ok <= (i != 3);
            i_mst.wr(OFF_MAP_ENTRY, ents[i]);
            i_mst.rd(OFF_MAP_STATUS, rdat);
            chk(32'(rdat[6:0]), 32'(errs[i]));
        end
        i_mst.wr(OFF_SM_ASSIGN, 32'h0000_003F);
        i_mst.rd(OFF_MAP_STATUS, rdat);
        chk(32'(rdat[6:0]), 32'h3E);
        i_mst.wr(OFF_MAP_STATUS, 32'h7F);
        i_mst.rd(OFF_MAP_STATUS, rdat);
        chk(rdat, 32'h0204_0100);
        i_mst.rd(8'hF0, rdat);
        chk(rdat, 32'h0);
        // Mid-run reset clears the state word
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        i_mst.rd(OFF_TX_STATE, rdat);
        chk(rdat, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
